// ===== ssau_pkg.sv
package ssau_pkg;

   // ----------------------------------------------------------------------
   // Widths and lane layout
   // ----------------------------------------------------------------------
   localparam int unsigned WORD_W  = 32;
   localparam int unsigned HALF_W  = 16;
   localparam int unsigned BYTE_W  = 8;
   localparam int unsigned LANES   = 2;
   localparam int unsigned OP_W    = 4;

   // ----------------------------------------------------------------------
   // Clamp values
   // ----------------------------------------------------------------------
   localparam logic [HALF_W-1:0] S16_MAX = 16'h7FFF;
   localparam logic [HALF_W-1:0] S16_MIN = 16'h8000;
   localparam logic [HALF_W-1:0] U16_MAX = 16'hFFFF;
   localparam logic [HALF_W-1:0] U16_MIN = 16'h0000;
   localparam logic [BYTE_W-1:0] U8_MAX  = 8'hFF;
   localparam logic [BYTE_W-1:0] U8_MIN  = 8'h00;
   localparam logic [WORD_W-1:0] S32_MAX = 32'h7FFFFFFF;
   localparam logic [WORD_W-1:0] S32_MIN = 32'h80000000;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [WORD_W-1:0] WB_DATA_RST = 32'h00000000;
   localparam logic              SAT_RST     = 1'h0;

   // ----------------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------------
   typedef enum logic [OP_W-1:0] {
      signed_add_sub_exchange    = 4'h0,
      signed_sub_add_exchange    = 4'h1,
      doubling_sat_add           = 4'h2,
      doubling_sat_sub           = 4'h3,
      unsigned_add_sub_exchange  = 4'h4,
      unsigned_sub_add_exchange  = 4'h5,
      unsigned_halfword_sat_add  = 4'h6,
      unsigned_byte_sat_add      = 4'h7,
      unsigned_halfword_sat_sub  = 4'h8,
      unsigned_byte_sat_sub      = 4'h9
   } ssau_op_t;

endpackage

// ===== ssau_lane_if.sv
`timescale 1ns/1ps
interface ssau_lane_if;
   import ssau_pkg::*;
   logic [HALF_W-1:0] a;
   logic [HALF_W-1:0] b;
   logic              sub;
   logic              sgn;
   logic              byte_mode;
   logic [HALF_W-1:0] res;

   modport alu (input a, input b, input sub, input sgn, input byte_mode, output res);
   modport ctl (output a, output b, output sub, output sgn, output byte_mode, input res);
endinterface

// ===== ssau_lane_alu.sv
`timescale 1ns/1ps
module ssau_lane_alu
   import ssau_pkg::*;
(
   ssau_lane_if.alu lane
);

   // ----------------------------------------------------------------------
   // Halfword arithmetic, one bit wider than the lane
   // ----------------------------------------------------------------------
   wire [HALF_W:0] a_ext = {lane.sgn & lane.a[HALF_W-1], lane.a};
   wire [HALF_W:0] b_ext = {lane.sgn & lane.b[HALF_W-1], lane.b};
   wire [HALF_W:0] h_raw = lane.sub ? (a_ext - b_ext) : (a_ext + b_ext);

   // Signed overflow shows as disagreement of the top two bits.
   wire            s_ovf = h_raw[HALF_W] ^ h_raw[HALF_W-1];
   wire [HALF_W-1:0] s_res = s_ovf ? (h_raw[HALF_W] ? S16_MIN : S16_MAX)
                                   : h_raw[HALF_W-1:0];
   // Unsigned: the extra bit is a carry on add and a borrow on subtract.
   wire [HALF_W-1:0] u_res = h_raw[HALF_W] ? (lane.sub ? U16_MIN : U16_MAX)
                                           : h_raw[HALF_W-1:0];

   // ----------------------------------------------------------------------
   // Two independent byte lanes
   // ----------------------------------------------------------------------
   wire [HALF_W-1:0] byte_res;

   // Each byte keeps its own carry or borrow, so no lane can spill into its neighbour.
   genvar bi;
   generate
      for (bi = 0; bi < HALF_W / BYTE_W; bi = bi + 1) begin : g_byte
         wire [BYTE_W-1:0] ba   = lane.a[bi*BYTE_W +: BYTE_W];
         wire [BYTE_W-1:0] bb   = lane.b[bi*BYTE_W +: BYTE_W];
         wire [BYTE_W:0]   braw = lane.sub ? ({1'h0, ba} - {1'h0, bb}) : ({1'h0, ba} + {1'h0, bb});
         assign byte_res[bi*BYTE_W +: BYTE_W] = braw[BYTE_W] ? (lane.sub ? U8_MIN : U8_MAX)
                                                             : braw[BYTE_W-1:0];
      end
   endgenerate

   assign lane.res = lane.byte_mode ? byte_res : (lane.sgn ? s_res : u_res);

endmodule

// ===== ssau_top.sv
`timescale 1ns/1ps
module ssau_top
   import ssau_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_issue,
   input  wire logic [OP_W-1:0]   i_opcode,
   input  wire logic              i_cond_pass,
   input  wire logic [WORD_W-1:0] i_first_operand,
   input  wire logic [WORD_W-1:0] i_second_operand,
   input  wire logic              i_status_write,
   input  wire logic              i_status_sat_wdata,
   output logic                   o_wb_valid,
   output logic [WORD_W-1:0]      o_wb_data,
   output logic                   o_sat_flag
);

   // ----------------------------------------------------------------------
   // Opcode decode
   // ----------------------------------------------------------------------
   wire ssau_op_t op = ssau_op_t'(i_opcode);

   wire is_sasx  = (op == signed_add_sub_exchange);
   wire is_ssax  = (op == signed_sub_add_exchange);
   wire is_uasx  = (op == unsigned_add_sub_exchange);
   wire is_usax  = (op == unsigned_sub_add_exchange);
   wire is_hadd  = (op == unsigned_halfword_sat_add);
   wire is_hsub  = (op == unsigned_halfword_sat_sub);
   wire is_badd  = (op == unsigned_byte_sat_add);
   wire is_bsub  = (op == unsigned_byte_sat_sub);
   wire is_dadd  = (op == doubling_sat_add);
   wire is_dsub  = (op == doubling_sat_sub);

   wire is_dbl   = is_dadd | is_dsub;
   wire is_exch  = is_sasx | is_ssax | is_uasx | is_usax;
   wire is_lane  = is_exch | is_hadd | is_hsub | is_badd | is_bsub;
   wire is_known = is_lane | is_dbl;

   // Per lane subtract select; lane 1 is the upper halfword.
   wire [LANES-1:0] lane_sub;
   assign lane_sub[1] = is_ssax | is_usax | is_hsub | is_bsub;
   assign lane_sub[0] = is_sasx | is_uasx | is_hsub | is_bsub;
   wire lane_sgn  = is_sasx | is_ssax;
   wire lane_byte = is_badd | is_bsub;

   // ----------------------------------------------------------------------
   // Halfword lanes
   // ----------------------------------------------------------------------
   wire [WORD_W-1:0] lane_word;

   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi = gi + 1) begin : g_lane
         ssau_lane_if lif ();
         assign lif.a  = i_first_operand[gi*HALF_W +: HALF_W];
         // Exchange forms pair each first-operand half with the opposite second-operand half.
         assign lif.b  = is_exch ? i_second_operand[(LANES-1-gi)*HALF_W +: HALF_W]
                                 : i_second_operand[gi*HALF_W +: HALF_W];
         assign lif.sub       = lane_sub[gi];
         assign lif.sgn       = lane_sgn;
         assign lif.byte_mode = lane_byte;
         ssau_lane_alu u_alu (
            .lane (lif.alu)
         );
         assign lane_word[gi*HALF_W +: HALF_W] = lif.res;
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Doubling add and subtract
   // ----------------------------------------------------------------------
   // Doubling overflows exactly when the top two bits of the second operand differ.
   wire              dbl_ovf = i_second_operand[WORD_W-1] ^ i_second_operand[WORD_W-2];
   wire [WORD_W-1:0] dbl_val = dbl_ovf ? (i_second_operand[WORD_W-1] ? S32_MIN : S32_MAX)
                                       : {i_second_operand[WORD_W-2:0], 1'h0};
   wire [WORD_W:0]   fin_a   = {i_first_operand[WORD_W-1], i_first_operand};
   wire [WORD_W:0]   fin_b   = {dbl_val[WORD_W-1], dbl_val};
   wire [WORD_W:0]   fin_raw = is_dsub ? (fin_a - fin_b) : (fin_a + fin_b);
   wire              fin_ovf = fin_raw[WORD_W] ^ fin_raw[WORD_W-1];
   wire [WORD_W-1:0] dbl_res = fin_ovf ? (fin_raw[WORD_W] ? S32_MIN : S32_MAX)
                                       : fin_raw[WORD_W-1:0];
   wire              dbl_sat = dbl_ovf | fin_ovf;

   // ----------------------------------------------------------------------
   // Commit
   // ----------------------------------------------------------------------
   // An unknown opcode is dropped rather than written, so stray decode cannot corrupt a register.
   wire              commit   = i_issue & i_cond_pass & is_known;
   wire [WORD_W-1:0] res_word = is_dbl ? dbl_res : lane_word;
   // Lane ops never raise the flag, so only doubling feeds the set term.
   wire              sat_set  = commit & is_dbl & dbl_sat;
   // A set arriving with a clearing status write still wins.
   wire              sat_d    = sat_set | (i_status_write ? i_status_sat_wdata : o_sat_flag);
   wire [WORD_W-1:0] wb_d     = commit ? res_word : o_wb_data;

   // The unit owns no condition flags at all, so they are never written here.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wb_valid <= 1'h0;
         o_wb_data  <= WB_DATA_RST;
         o_sat_flag <= SAT_RST;
      end else begin
         o_wb_valid <= commit;
         o_wb_data  <= wb_d;
         o_sat_flag <= sat_d;
      end
   end

endmodule

// ===== ssau_assertions.sv
`timescale 1ns/1ps
module ssau_assertions
   import ssau_pkg::*;
(
   input wire logic              i_ref_clk,
   input wire logic              i_rst_n,
   input wire logic              i_issue,
   input wire logic [OP_W-1:0]   i_opcode,
   input wire logic              i_cond_pass,
   input wire logic [WORD_W-1:0] i_first_operand,
   input wire logic [WORD_W-1:0] i_second_operand,
   input wire logic              i_status_write,
   input wire logic              i_status_sat_wdata,
   input wire logic              o_wb_valid,
   input wire logic [WORD_W-1:0] o_wb_data,
   input wire logic              o_sat_flag
);
   // ---------------------------------------------------------------
   // Write-back and sticky flag checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   wire dbl = i_issue && i_cond_pass && i_opcode[3:1] == 3'h1;
   sequence s_commit; i_issue && i_cond_pass && i_opcode <= 4'h9; endsequence
   sequence s_byte_top; s_commit ##0 i_opcode == 4'h7 ##0 i_first_operand[7:0] == 8'hFF; endsequence
   sequence s_half_neg; s_commit ##0 i_opcode == 4'h8 ##0 i_first_operand[15:0] < i_second_operand[15:0]; endsequence
   commit_wb_a: assert property (s_commit |=> o_wb_valid)
      else $error("Committed operation gave no write-back.");
   refuse_hold_a: assert property (!(i_issue && i_cond_pass && i_opcode <= 4'h9) |=> !o_wb_valid && $stable(o_wb_data))
      else $error("Refused operation changed the write-back.");
   flag_hold_a: assert property (!i_status_write && !dbl |=> $stable(o_sat_flag))
      else $error("Sticky flag moved without cause.");
   flag_clear_a: assert property (i_status_write && !i_status_sat_wdata && !dbl |=> !o_sat_flag)
      else $error("Status write did not clear the sticky flag.");
   flag_set_a: assert property (i_status_write && i_status_sat_wdata |=> o_sat_flag)
      else $error("Status write did not set the sticky flag.");
   dbl_clamp_a: assert property (dbl && i_second_operand[31] != i_second_operand[30] |=> o_sat_flag)
      else $error("Clamped doubling left the sticky flag clear.");
   byte_clamp_a: assert property (s_byte_top |=> o_wb_data[7:0] == 8'hFF)
      else $error("Byte add did not clamp to all ones.");
   half_floor_a: assert property (s_half_neg |=> o_wb_data[15:0] == 16'h0000)
      else $error("Halfword subtract did not clamp to zero.");
endmodule

bind ssau_top ssau_assertions u_chk (.*);

// ===== ssau_pipe_model.sv
`timescale 1ns/1ps
module ssau_pipe_model
   import ssau_pkg::*;
(
   input  wire logic              i_ref_clk,
   output logic                   o_issue,
   output logic [OP_W-1:0]        o_opcode,
   output logic                   o_cond_pass,
   output logic [WORD_W-1:0]      o_first_operand,
   output logic [WORD_W-1:0]      o_second_operand,
   output logic                   o_status_write,
   output logic                   o_status_sat_wdata
);
   // ---------------------------------------------------------------
   // Issue slot
   // ---------------------------------------------------------------
   initial {o_issue, o_opcode, o_cond_pass, o_first_operand, o_second_operand, o_status_write, o_status_sat_wdata} = '0;
   // Idle operands are scrambled so that the unit cannot lean on stale values.
   task automatic issue(input logic v, input logic [3:0] op, input logic c, input logic [31:0] x, y, input logic w, d);
      @(posedge i_ref_clk);
      #1;
      {o_issue, o_opcode, o_cond_pass, o_status_write, o_status_sat_wdata} = {v, op, c, w, d};
      o_first_operand = v ? x : ~o_first_operand;
      o_second_operand = v ? y : o_second_operand + 32'h9E3779B9;
   endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
   import ssau_pkg::*;
   localparam longint MX = 64'sh7FFFFFFF;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              issue, cond, sw, sd, valid, flag;
   logic [OP_W-1:0]   opc;
   logic [WORD_W-1:0] a, b, data;
   logic [32:0]       exp_q[$];
   logic [32:0]       e;
   logic              exp_flag = 1'b0;
   integer            seed = 99;
   int                n_errors = 0;
   int                n_compared = 0;
   int                cycles = 0;
   always #50 clk = ~clk;
   ssau_pipe_model u_pipe (.i_ref_clk(clk), .o_issue(issue), .o_opcode(opc), .o_cond_pass(cond),
      .o_first_operand(a), .o_second_operand(b), .o_status_write(sw), .o_status_sat_wdata(sd));
   ssau_top DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_issue(issue), .i_opcode(opc), .i_cond_pass(cond),
      .i_first_operand(a), .i_second_operand(b), .i_status_write(sw), .i_status_sat_wdata(sd),
      .o_wb_valid(valid), .o_wb_data(data), .o_sat_flag(flag));
   // ---------------------------------------------------------------
   // Reference model and checking
   // ---------------------------------------------------------------
   function automatic longint cl(longint v, longint lo, longint hi);
      return v < lo ? lo : (v > hi ? hi : v);
   endfunction
   function automatic logic [32:0] model(logic [3:0] op, logic [31:0] x, logic [31:0] y);
      longint ah, al, bh, bl, lo, hi, d, s;
      logic [31:0] r = 32'h0;
      logic        q = 1'b0;
      lo = op < 2 ? -32768 : 0;
      hi = op < 2 ? 32767 : 65535;
      if (op < 2) begin
         {ah, al, bh, bl} = {longint'($signed(x[31:16])), longint'($signed(x[15:0])),
                             longint'($signed(y[31:16])), longint'($signed(y[15:0]))};
      end else begin
         {ah, al, bh, bl} = {longint'(x[31:16]), longint'(x[15:0]), longint'(y[31:16]), longint'(y[15:0])};
      end
      case (op)
         0, 4: r = {16'(cl(ah + bl, lo, hi)), 16'(cl(al - bh, lo, hi))};
         1, 5: r = {16'(cl(ah - bl, lo, hi)), 16'(cl(al + bh, lo, hi))};
         6: r = {16'(cl(ah + bh, lo, hi)), 16'(cl(al + bl, lo, hi))};
         8: r = {16'(cl(ah - bh, lo, hi)), 16'(cl(al - bl, lo, hi))};
         7, 9: for (int k = 0; k < 4; k++) r[8*k+:8] = 8'(cl(op == 7 ? longint'(x[8*k+:8]) + longint'(y[8*k+:8])
                                                              : longint'(x[8*k+:8]) - longint'(y[8*k+:8]), 0, 255));
         2, 3: begin
            d = cl(2 * longint'($signed(y)), -MX - 1, MX);
            s = op == 2 ? longint'($signed(x)) + d : longint'($signed(x)) - d;
            q = d != 2 * longint'($signed(y)) || s != cl(s, -MX - 1, MX);
            r = 32'(cl(s, -MX - 1, MX));
         end
         default: r = 32'h0;
      endcase
      return {q, r};
   endfunction
   task automatic check(input string what, input logic [31:0] ex, input logic [31:0] sn);
      n_compared++;
      if (sn !== ex) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, ex, sn);
      end
   endtask
   task automatic final_report();
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic run_op(input logic [3:0] o, input logic c, input logic [31:0] x, y, input logic w, v);
      logic [32:0] m;
      logic        go;
      m = model(o, x, y);
      go = c && o <= 4'h9;
      u_pipe.issue(1'b1, o, c, x, y, w, v);
      exp_flag = (w ? v : exp_flag) | (go & m[32]);
      if (go) exp_q.push_back({exp_flag, m[31:0]});
   endtask
   always @(negedge clk) begin
      if (rst_n && valid === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
         check("wb_data", e[31:0], data);
         check("sat_flag", {31'h0, e[32]}, {31'h0, flag});
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         final_report();
      end
   end
   // Every opcode, plus two unused codes, gets corner operands and a random burst with status writes mixed in.
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int o = 0; o < 12; o++) begin
         run_op(4'(o), 1'b1, 32'h7FFF8000, 32'h80007FFF, 1'b0, 1'b0);
         run_op(4'(o), 1'b1, 32'h00FF00FF, 32'hFF01FFFF, 1'b0, 1'b0);
         run_op(4'(o), 1'b1, 32'h7FFFFFFF, 32'h40000000, 1'b1, 1'b0);
         repeat (24) run_op(4'(o), $random(seed) % 4 != 0, $random(seed), $random(seed),
                            $random(seed) % 8 == 0, $random(seed) % 2 != 0);
         u_pipe.issue(1'b0, 4'h0, 1'b0, 32'h0, 32'h0, 1'b0, 1'b0);
      end
      repeat (3) @(posedge clk);
      check("pending", 32'h0, 32'(exp_q.size()));
      final_report();
   end
endmodule
